// ==== common/sep_defines.svh ====
// Notes on behaviour
// RULE1 - Serial output changes after each falling serial clock edge.
// RULE2 - Input bits captured on rising serial clock edges; host keeps them stable.
// RULE3 - Chip select high deselects, output floats; standby unless a write runs.
// RULE4 - Nothing accepted after power-on until chip select falls.
// RULE5 - Write-protect low blocks all nonvolatile writes; otherwise normal operation.
// RULE6 - Write-protect falling during selection aborts pending write; running cycle unaffected.
// RULE7 - Hold changes only while serial clock low; sequence state kept across pause.
// RULE8 - While held, input transitions ignored; resume exactly where paused.
// RULE9 - First eight bits after select form the opcode register.
// RULE10 - Opcode, address and data travel most significant bit first.
// RULE11 - First bit taken on first rising clock edge after select falls.
// RULE12 - Fully static: clock may stop anywhere without losing state.
// RULE13 - Latch set and clear opcodes; writes complete only with latch set.
// RULE14 - Latch cleared at power-on and when a write cycle completes; code clears it only when an array write ends, not a status write.
// RULE15 - Latch cleared whenever write-protect is low.
// RULE16 - Status read opcode shifts out status, even during a write.
// RULE17 - Status: busy bit0, latch bit1, protection bits 2 and 3.
// RULE18 - Busy reads one during write, and all other status bits read one.
// RULE19 - Latch-status bit mirrors the write-enable latch.
// RULE20 - Status write loads protection level; protected segments reject writes.
// RULE21 - Read opcode plus address streams array data from that address.
// RULE22 - Write opcode plus address accepts one to four data bytes.
// RULE23 - Host keeps select low, hold and write-protect high per operation.
// RULE24 - Read address increments after each byte, wrapping to zero.
// RULE25 - Write starts only if select rises after clock 24, 32, 40 or 48.
// RULE26 - Page write advances low two address bits, wrapping inside the page.
// RULE27 - Latch-set honoured only if select rises right after its eight bits.
// RULE28 - Unknown opcode ignored, output floats until select rises.
// RULE29 - Busy from the select rise of a valid write until cycle ends.
`ifndef SEP_DEFINES_SVH
`define SEP_DEFINES_SVH

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define SEP_OP_SET_LATCH    8'h06
`define SEP_OP_CLEAR_LATCH  8'h04
`define SEP_OP_READ_STATUS  8'h05
`define SEP_OP_WRITE_STATUS 8'h01
`define SEP_OP_READ_ARRAY   8'h03
`define SEP_OP_WRITE_ARRAY  8'h02

// ----------------------------------------
// Status layout and counts
// ----------------------------------------
`define SEP_ST_BUSY         0
`define SEP_ST_LATCH        1
`define SEP_ST_PROT_LO      2
`define SEP_ST_PROT_HI      3
`define SEP_ST_BUSY_VALUE   8'hFF
`define SEP_BYTE_BITS       4'h8
`define SEP_LAST_BIT        3'h7
`define SEP_PAGE_MAX        3'h4
`define SEP_PROT_RESET      2'h0
`define SEP_WRITE_TIME_NS   5000000
`define SEP_CLK_PERIOD_NS   10

`endif

// ==== common/sep_pkg.sv ====
package sep_pkg;

    // Sequencer states, Gray coded along opcode -> address -> data
    typedef enum logic [2:0] {
        SEP_IDLE   = 3'b000,
        SEP_OPCODE = 3'b001,
        SEP_ADDR   = 3'b011,
        SEP_DATA   = 3'b010,
        SEP_STAT   = 3'b110,
        SEP_WSTAT  = 3'b111,
        SEP_IGNORE = 3'b101
    } sep_state_e;

    // Cleaned link pin levels
    typedef struct packed {
        logic sck;
        logic cs_n;
        logic din;
        logic hold_n;
        logic wp_n;
    } sep_pins_s;

    // Edge events derived from the cleaned pins
    typedef struct packed {
        logic rise;
        logic fall;
        logic cs_fall;
        logic cs_rise;
    } sep_events_s;

endpackage

// ==== hw/sep_pin_sync.sv ====
`timescale 1ns/10ps
`include "sep_defines.svh"

module sep_pin_sync #(
    parameter int WIDTH = 5
) (
    input  wire logic             ref_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] pins_i,
    output logic      [WIDTH-1:0] clean_o
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] clean;
    } sep_sync_s;

    sep_sync_s st;
    sep_sync_s next_st;

    // Stage one is read only by stage two; level counts once two and three agree
    always_comb begin
        next_st       = st;
        next_st.s1    = pins_i;
        next_st.s2    = st.s1;
        next_st.s3    = st.s2;
        for (int i = 0; i < WIDTH; i++) begin
            if (st.s2[i] == st.s3[i]) begin
                next_st.clean[i] = st.s3[i];
            end
        end
    end

    // Idle levels high so no false select edge appears at reset
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            st <= '1;
        end else begin
            st <= next_st;
        end
    end

    assign clean_o = st.clean;

endmodule

// ==== hw/sep_write_timer.sv ====
`timescale 1ns/10ps
`include "sep_defines.svh"

module sep_write_timer #(
    parameter int WRITE_CYCLES = `SEP_WRITE_TIME_NS / `SEP_CLK_PERIOD_NS
) (
    input  wire logic ref_clk_i,
    input  wire logic rst_n_i,
    input  wire logic start_i,
    output logic      busy_o,
    output logic      done_o
);

    // ----------------------------------------
    // Self-timed internal write cycle
    // ----------------------------------------
    typedef struct packed {
        logic        busy;
        logic        done;
        logic [31:0] count;
    } sep_timer_s;

    sep_timer_s st;
    sep_timer_s next_st;

    // Counts down the nonvolatile program time; done pulses once at the end
    always_comb begin
        next_st      = st;
        next_st.done = 1'b0;
        if (st.busy) begin
            if (st.count <= 32'h0000_0001) begin
                next_st.busy = 1'b0;
                next_st.done = 1'b1;
            end else begin
                next_st.count = st.count - 32'h0000_0001;
            end
        end else if (start_i) begin
            next_st.busy  = 1'b1;
            next_st.count = 32'(WRITE_CYCLES);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign busy_o = st.busy;
    assign done_o = st.done;

endmodule

// ==== hw/sep_eeprom_slave.sv ====
`timescale 1ns/10ps
`include "sep_defines.svh"

module sep_eeprom_slave #(
    parameter int WRITE_CYCLES = `SEP_WRITE_TIME_NS / `SEP_CLK_PERIOD_NS,
    parameter int DEPTH        = 256
) (
    input  wire logic ref_clk_i,
    input  wire logic rst_n_i,
    input  wire logic sck_i,
    input  wire logic cs_n_i,
    input  wire logic din_i,
    input  wire logic hold_n_i,
    input  wire logic wp_n_i,
    output logic      dout_o,
    output logic      dout_oe_n_o,
    output logic      standby_o
);

    // ----------------------------------------
    // Pin cleaning
    // ----------------------------------------
    sep_pkg::sep_pins_s pins;
    logic [4:0]         clean;

    sep_pin_sync #(
        .WIDTH (5)
    ) u_sync (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .pins_i    ({sck_i, cs_n_i, din_i, hold_n_i, wp_n_i}),
        .clean_o   (clean)
    );

    assign pins = clean;

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        sep_pkg::sep_state_e state;
        sep_pkg::sep_pins_s  prev;
        logic                armed;      // A select fall has been seen since reset
        logic [3:0]          bit_cnt;
        logic [7:0]          shift;
        logic [7:0]          opcode;
        logic [7:0]          addr;
        logic [7:0]          tx;
        logic [2:0]          tx_bit;
        logic                tx_on;
        logic                dout;
        logic [2:0]          page_cnt;
        logic                byte_done;  // Clock count sits on a whole byte
        logic                latch;
        logic                latch_req;
        logic                wstat_req;
        logic [1:0]          wstat_val;
        logic [1:0]          prot;
        logic                aborted;
        logic                start;
        logic [3:0][7:0]     pend_data;  // Packed so the whole state stays one packed struct
        logic [7:0]          pend_addr;
        logic [1:0]          pend_cnt_m1;
        logic                pend_kind;  // 1 for array write, 0 for status write
    } sep_core_s;

    sep_core_s st;
    sep_core_s next_st;

    sep_pkg::sep_events_s ev;
    logic                 busy;
    logic                 done;
    logic [7:0]           mem [0:DEPTH-1];
    logic [7:0]           rdata;
    logic [7:0]           status;

    sep_write_timer #(
        .WRITE_CYCLES (WRITE_CYCLES)
    ) u_timer (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .start_i   (st.start),
        .busy_o    (busy),
        .done_o    (done)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Protected segment check: none, top quarter, upper half, all
    function automatic logic is_protected(input logic [1:0] lvl, input logic [7:0] a);
        logic r;
        r = 1'b0;
        case (lvl)
            2'b01:   r = (a[7:6] == 2'b11);
            2'b10:   r = a[7];
            2'b11:   r = 1'b1;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // Hold blocks every serial event; select edges stay live so a frame can end
    // Nothing times out between edges, so a stopped or paused clock loses no state
    assign ev.rise    = pins.sck & ~st.prev.sck & pins.hold_n & ~pins.cs_n;      // see RULE8 see RULE7 see RULE12
    assign ev.fall    = ~pins.sck & st.prev.sck & pins.hold_n & ~pins.cs_n;      // see RULE8
    assign ev.cs_fall = ~pins.cs_n & st.prev.cs_n;
    assign ev.cs_rise = pins.cs_n & ~st.prev.cs_n;

    // Status byte, forced all ones while a write runs
    always_comb begin
        status                   = '0;
        status[`SEP_ST_BUSY]     = busy;                      // see RULE17
        status[`SEP_ST_LATCH]    = st.latch;                  // see RULE19
        status[`SEP_ST_PROT_LO]  = st.prot[0];                // see RULE17
        status[`SEP_ST_PROT_HI]  = st.prot[1];
        if (busy || st.start) begin
            status = `SEP_ST_BUSY_VALUE;                      // see RULE18
        end
    end

    assign rdata = mem[st.addr];

    // ----------------------------------------
    // Serial sequencer
    // ----------------------------------------
    always_comb begin
        logic [7:0] byte_in;
        logic       wr_ok;
        byte_in       = {st.shift[6:0], pins.din};            // see RULE10
        wr_ok         = 1'b0;
        next_st       = st;
        next_st.prev  = pins;
        next_st.start = 1'b0;

        // Write-protect low drops the latch and any pending write in this frame
        if (!pins.wp_n) begin
            next_st.latch   = 1'b0;                           // see RULE15
            next_st.aborted = 1'b1;                           // see RULE6
        end
        if (done && st.pend_kind) begin
            next_st.latch = 1'b0;                             // see RULE14
        end

        if (ev.cs_fall) begin
            next_st.armed     = 1'b1;                         // see RULE4
            next_st.state     = sep_pkg::SEP_OPCODE;
            next_st.bit_cnt   = '0;
            next_st.page_cnt  = '0;
            next_st.byte_done = 1'b0;
            next_st.tx_on     = 1'b0;
            next_st.latch_req = 1'b0;
            next_st.wstat_req = 1'b0;
            next_st.aborted   = ~pins.wp_n;
        end else if (ev.cs_rise) begin
            // Frame end decides whether a write really starts
            wr_ok = st.byte_done && !st.aborted && pins.wp_n && st.latch && !busy; // see RULE5
            // Write-protect low is a level that keeps the latch cleared
            if (st.latch_req && pins.wp_n) begin
                next_st.latch = 1'b1;                         // see RULE27
            end
            if (st.state == sep_pkg::SEP_DATA && st.opcode == `SEP_OP_WRITE_ARRAY
                && st.page_cnt != '0 && wr_ok) begin          // see RULE25
                next_st.start       = 1'b1;                   // see RULE29
                next_st.pend_kind   = 1'b1;
                next_st.pend_cnt_m1 = 2'(st.page_cnt - 3'h1);
            end
            if (st.wstat_req && wr_ok) begin
                next_st.start     = 1'b1;                     // see RULE13
                next_st.pend_kind = 1'b0;
            end
            next_st.state = sep_pkg::SEP_IDLE;                // see RULE3
            next_st.tx_on = 1'b0;
        end else if (ev.rise && st.armed) begin
            // Sample on the rising edge, first one right after select
            next_st.shift = byte_in;                          // see RULE2 see RULE11
            next_st.bit_cnt = (st.bit_cnt == `SEP_BYTE_BITS - 4'h1) ? '0 : st.bit_cnt + 4'h1;
            next_st.byte_done = (st.bit_cnt == `SEP_BYTE_BITS - 4'h1);
            next_st.latch_req = 1'b0;
            next_st.wstat_req = 1'b0;
            if (st.bit_cnt == `SEP_BYTE_BITS - 4'h1) begin
                case (st.state)
                    sep_pkg::SEP_OPCODE: begin
                        next_st.opcode = byte_in;             // see RULE9
                        case (byte_in)
                            `SEP_OP_SET_LATCH: begin
                                next_st.latch_req = 1'b1;     // see RULE13
                                next_st.state     = sep_pkg::SEP_IGNORE;
                            end
                            `SEP_OP_CLEAR_LATCH: begin
                                next_st.latch = 1'b0;         // see RULE13
                                next_st.state = sep_pkg::SEP_IGNORE;
                            end
                            `SEP_OP_READ_STATUS: begin
                                next_st.state = sep_pkg::SEP_STAT;   // see RULE16
                                next_st.tx    = status;
                                next_st.tx_bit = `SEP_LAST_BIT;
                            end
                            `SEP_OP_WRITE_STATUS: next_st.state = sep_pkg::SEP_WSTAT;
                            `SEP_OP_READ_ARRAY:   next_st.state = sep_pkg::SEP_ADDR;
                            `SEP_OP_WRITE_ARRAY:  next_st.state = sep_pkg::SEP_ADDR;
                            default: next_st.state = sep_pkg::SEP_IGNORE; // see RULE28
                        endcase
                    end
                    sep_pkg::SEP_ADDR: begin
                        next_st.addr      = byte_in;
                        next_st.pend_addr = byte_in;
                        next_st.state     = sep_pkg::SEP_DATA;
                        if (st.opcode == `SEP_OP_READ_ARRAY) begin
                            next_st.tx     = mem[byte_in];    // see RULE21
                            next_st.tx_bit = `SEP_LAST_BIT;
                        end
                    end
                    sep_pkg::SEP_DATA: begin
                        if (st.opcode == `SEP_OP_WRITE_ARRAY && !busy) begin
                            // Low address bits wrap inside the page
                            next_st.pend_data[st.page_cnt[1:0] + st.pend_addr[1:0]] =
                                byte_in;                      // see RULE26 see RULE22
                            next_st.page_cnt = (st.page_cnt == `SEP_PAGE_MAX) ?
                                `SEP_PAGE_MAX : st.page_cnt + 3'h1;
                            if (st.page_cnt == `SEP_PAGE_MAX) begin
                                next_st.aborted = 1'b1;       // see RULE25
                            end
                        end
                    end
                    sep_pkg::SEP_WSTAT: begin
                        next_st.wstat_val = byte_in[`SEP_ST_PROT_HI:`SEP_ST_PROT_LO];
                        next_st.wstat_req = 1'b1;             // see RULE20
                        next_st.state     = sep_pkg::SEP_IGNORE;
                    end
                    default: ;
                endcase
            end
        end else if (ev.fall && st.armed) begin
            // Output changes on the falling edge, address steps per byte
            case (st.state)
                sep_pkg::SEP_STAT, sep_pkg::SEP_DATA: begin
                    if (st.state == sep_pkg::SEP_STAT || st.opcode == `SEP_OP_READ_ARRAY) begin
                        next_st.tx_on = 1'b1;
                        next_st.dout  = st.tx[st.tx_bit];     // see RULE1 see RULE10
                        if (st.tx_bit == '0) begin
                            next_st.tx_bit = `SEP_LAST_BIT;
                            next_st.tx     = (st.state == sep_pkg::SEP_STAT) ? status
                                : mem[st.addr + 8'h01];
                            if (st.state == sep_pkg::SEP_DATA) begin
                                next_st.addr = st.addr + 8'h01; // see RULE24
                            end
                        end else begin
                            next_st.tx_bit = st.tx_bit - 3'h1;
                        end
                    end
                end
                default: ;
            endcase
        end
    end

    // Memory and status commit happen when the self-timed cycle ends
    always_ff @(posedge ref_clk_i) begin
        if (done && st.pend_kind) begin
            for (int i = 0; i < 4; i++) begin
                if (2'(i) <= st.pend_cnt_m1
                    && !is_protected(st.prot, {st.pend_addr[7:2], 2'(st.pend_addr[1:0] + 2'(i))})) begin
                    mem[{st.pend_addr[7:2], 2'(st.pend_addr[1:0] + 2'(i))}] <=
                        st.pend_data[2'(st.pend_addr[1:0] + 2'(i))];          // see RULE20
                end
            end
        end
    end

    // Registered state; protection bits take the pending value at cycle end
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            st       <= '0;
            st.prev  <= '1;
            st.prot  <= `SEP_PROT_RESET;
        end else begin
            st <= next_st;
            if (done && !st.pend_kind) begin
                st.prot <= st.wstat_val;
            end
        end
    end

    // Output floats when deselected, held or after an unknown opcode
    assign dout_o      = st.dout;
    assign dout_oe_n_o = ~(st.tx_on && !pins.cs_n && pins.hold_n);   // see RULE3 see RULE8
    assign standby_o   = pins.cs_n && !busy && !st.start;            // see RULE3

endmodule

// ==== bench/sep_slave_properties.sv ====
`timescale 1ns/10ps

// ----------------------------------------
// Pin-level checker, sees the slave ports only
// ----------------------------------------
module sep_slave_properties (
    input  wire logic ref_clk_i,
    input  wire logic rst_n_i,
    input  wire logic sck_i,
    input  wire logic cs_n_i,
    input  wire logic din_i,
    input  wire logic hold_n_i,
    input  wire logic wp_n_i,
    input  wire logic dout_o,
    input  wire logic dout_oe_n_o,
    input  wire logic standby_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // Six cycles covers the four-flop pin synchroniser plus margin
    property p_float_idle;
        cs_n_i [*6] |-> dout_oe_n_o;
    endproperty
    property p_oe_rise;
        $rose(cs_n_i) |-> ##[1:6] dout_oe_n_o;
    endproperty
    property p_standby_sel;
        !cs_n_i [*6] |-> !standby_o;
    endproperty
    property p_standby_fall;
        $fell(cs_n_i) |-> ##[1:6] !standby_o;
    endproperty
    // Output may only move in the low half of the serial clock
    property p_dout_low;
        !dout_oe_n_o && $changed(dout_o) |-> !sck_i;
    endproperty
    property p_dout_high_stable;
        sck_i [*6] |-> $stable(dout_o);
    endproperty
    property p_hold_float;
        !hold_n_i [*6] |-> dout_oe_n_o;
    endproperty
    property p_hold_frozen;
        $fell(hold_n_i) |=> $stable(dout_o) [*8];
    endproperty

    a_float_idle: assert property (p_float_idle) else $error("output driven while deselected");
    a_oe_rise: assert property (p_oe_rise) else $error("output still driven after deselect");
    a_standby_sel: assert property (p_standby_sel) else $error("standby while selected");
    a_standby_fall: assert property (p_standby_fall) else $error("standby kept after select");
    a_dout_low: assert property (p_dout_low) else $error("output moved with clock high");
    a_dout_high_stable: assert property (p_dout_high_stable) else $error("output moved late");
    a_hold_float: assert property (p_hold_float) else $error("output driven during pause");
    a_hold_frozen: assert property (p_hold_frozen) else $error("output moved during pause");

    c_driving: cover property ($fell(dout_oe_n_o));
    c_pause: cover property (!hold_n_i && !cs_n_i);
    c_standby: cover property ($rose(standby_o));
endmodule

// ==== bench/sep_host_model.sv ====
`timescale 1ns/10ps

// ----------------------------------------
// Host master model, mode 0, 240 ns serial clock
// ----------------------------------------
module sep_host_model (
    input  wire logic ref_clk_i,
    input  wire logic dout_i,
    output logic      sck_o,
    output logic      cs_n_o,
    output logic      din_o,
    output logic      hold_n_o,
    output logic      wp_n_o
);
    // Idle levels at time zero; clock stands low between frames
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        din_o = 1'b0;
        hold_n_o = 1'b1;
        wp_n_o = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask

    // One frame, MSB first; hold_at pauses before that bit index, -1 for none
    task automatic frame(input logic [47:0] tx, input int nbits, input int hold_at,
                         output logic [47:0] rx);
        rx = '0;
        tick(1);
        cs_n_o <= 1'b0;
        for (int i = nbits - 1; i >= 0; i--) begin
            tick(8);
            if (i == hold_at) begin
                hold_n_o <= 1'b0;
                // Clock and data keep moving; the slave must ignore them
                for (int k = 0; k < 4; k++) begin
                    tick(8);
                    sck_o <= ~sck_o;
                    din_o <= ~din_o;
                end
                tick(8);
                hold_n_o <= 1'b1;
                tick(8);
            end
            din_o <= tx[i];
            tick(8);
            sck_o <= 1'b1;
            rx = {rx[46:0], dout_i};
            tick(8);
            sck_o <= 1'b0;
        end
        tick(8);
        cs_n_o <= 1'b1;
        din_o <= ~din_o; // Stale data must not look meaningful
        tick(8);
    endtask
endmodule

// ==== bench/sep_eeprom_slave_tb_top.sv ====
`timescale 1ns/10ps

module sep_eeprom_slave_tb_top;
    logic        ref_clk_i;
    logic        rst_n_i;
    logic        sck, cs_n, din, hold_n, wp_n, dout, dout_oe_n, standby;
    logic        oe_seen;
    logic [47:0] rx;
    int          n_mismatch = 0;
    int          checks_done = 0;

    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    // Short write time keeps the run small
    sep_eeprom_slave #(.WRITE_CYCLES(400)) u_dut (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .sck_i(sck), .cs_n_i(cs_n),
        .din_i(din), .hold_n_i(hold_n), .wp_n_i(wp_n), .dout_o(dout),
        .dout_oe_n_o(dout_oe_n), .standby_o(standby));

    sep_host_model u_host (
        .ref_clk_i(ref_clk_i), .dout_i(dout), .sck_o(sck), .cs_n_o(cs_n),
        .din_o(din), .hold_n_o(hold_n), .wp_n_o(wp_n));

    always @(posedge ref_clk_i) if (!dout_oe_n) oe_seen <= 1'b1;

    // ----------------------------------------
    // Shared helpers
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic op(input logic [47:0] tx, input int n);
        u_host.frame(tx, n, -1, rx);
    endtask

    // Poll status until the busy flag clears, bounded
    task automatic wait_idle();
        for (int k = 0; k < 12; k++) begin
            op(16'h0500, 16);
            if (rx[0] === 1'b0) return;
        end
        n_mismatch++;
        finish_test();
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset_status();
        op(16'h0500, 16);
        check(rx[3:0], 4'h0);
        $display("test reset_status done");
    endtask

    task automatic t_latch();
        op(8'h06, 8);
        op(16'h0500, 16);
        check(rx[1], 1'b1);
        op(8'h04, 8);
        op(16'h0500, 16);
        check(rx[1], 1'b0);
        op(16'h0600, 16);
        op(16'h0500, 16);
        check(rx[1], 1'b0);
        $display("test latch done");
    endtask

    task automatic t_page();
        op(8'h06, 8);
        op(48'h02FE_A1A2_A3A4, 48);
        op(16'h0500, 16);
        check(rx[7:0], 8'hFF);
        wait_idle();
        check(rx[1], 1'b0);
        u_host.frame(48'h03FC_0000_0000, 48, 30, rx);
        check(rx[31:0], 32'hA3A4_A1A2);
        $display("test page done");
    endtask

    task automatic t_refuse();
        op(8'h06, 8);
        op(28'h02F_C555, 28);
        op(16'h0500, 16);
        check(rx[0], 1'b0);
        op(8'h06, 8);
        fork
            op(24'h02_FC55, 24);
            begin
                u_host.tick(200);
                u_host.wp_n_o <= 1'b0;
            end
        join
        op(16'h0500, 16);
        check(rx[1:0], 2'b00);
        u_host.wp_n_o <= 1'b1;
        $display("test refuse done");
    endtask

    task automatic t_protect();
        op(8'h06, 8);
        op(16'h010C, 16);
        wait_idle();
        check(rx[3:2], 2'b11);
        op(8'h06, 8);
        op(24'h02_FC66, 24);
        wait_idle();
        op(24'h03_FC00, 24);
        check(rx[7:0], 8'hA3);
        $display("test protect done");
    endtask

    task automatic t_bad_opcode();
        oe_seen = 1'b0;
        op(16'hFF00, 16);
        check(oe_seen, 1'b0);
        $display("test bad_opcode done");
    endtask

    initial begin
        rst_n_i = 1'b0;
        oe_seen = 1'b0;
        repeat (5) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        repeat (5) @(posedge ref_clk_i);
        t_reset_status();
        t_latch();
        t_page();
        t_refuse();
        t_protect();
        t_bad_opcode();
        finish_test();
    end
endmodule

bind sep_eeprom_slave sep_slave_properties u_props (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .sck_i(sck_i), .cs_n_i(cs_n_i),
    .din_i(din_i), .hold_n_i(hold_n_i), .wp_n_i(wp_n_i), .dout_o(dout_o),
    .dout_oe_n_o(dout_oe_n_o), .standby_o(standby_o));
